// [rtl/ptr_fifo.sv]
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module ptr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic flush,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem[rp_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb
   begin
      wp_d = wp_q;
      rp_d = rp_q;
      cnt_d = cnt_q;
      if (flush)
      begin
         wp_d = '0;
         rp_d = '0;
         cnt_d = '0;
      end
      else
      begin
         if (push)
            wp_d = wp_q + 1'b1;
         if (pop)
            rp_d = rp_q + 1'b1;
         if (push && !pop)
            cnt_d = cnt_q + 1'b1;
         else if (pop && !push)
            cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
      end
   end

   // Storage has no reset; contents are gated by the count
   always_ff @(posedge sys_clk)
   begin
      if (push && !flush)
         mem[wp_q] <= in_data;
   end
endmodule : ptr_fifo

// [rtl/ptr_pkg.sv]
// Package of constants for the parameter table read responder
package ptr_pkg;
   localparam logic [7:0] OPCODE_READ_PARAM = 8'h5a;
   localparam int ADDR_BITS = 24;
   localparam int HDR_BITS = 40;
   localparam logic [7:0] BYTE_UNUSED = 8'hff;
   localparam logic [31:0] SIGNATURE = 32'h50444653;
   localparam logic [7:0] REV_MINOR = 8'h00;
   localparam logic [7:0] REV_MAJOR = 8'h01;
   localparam logic [7:0] HEADER_COUNT_FIELD = 8'h01;
   localparam logic [7:0] STD_TABLE_ID = 8'h00;
   localparam logic [7:0] STD_TABLE_LEN = 8'h09;
   localparam logic [23:0] STD_TABLE_POINTER_FIELD = 24'h000030;
   localparam logic [7:0] VND_TABLE_LEN = 8'h04;
   localparam logic [23:0] VND_TABLE_POINTER_FIELD = 24'h000060;
   localparam logic [7:0] ADDR_SIG0 = 8'h00;
   localparam logic [7:0] ADDR_HDR1 = 8'h08;
   localparam logic [7:0] ADDR_HDR2 = 8'h10;
   localparam logic [7:0] ADDR_PARAM0 = 8'h30;
   // Byte 30h: erase 01b, granularity 1, bp 0, wren 0, top 111b
   localparam logic [1:0] ERASE_4K = 2'h1;
   localparam logic GRAN_64 = 1'b1;
   localparam logic BP_NONVOL = 1'b0;
   localparam logic WREN_50 = 1'b0;
   localparam logic [2:0] TOP_UNUSED = 3'h7;
   localparam int FIFO_DEPTH = 16;
endpackage : ptr_pkg

// [rtl/ptr_responder.sv]
// Parameter table read responder on the serial flash link
// Notes on behaviour
// - Host sends opcode 5Ah, 24-bit address MSB first, one dummy byte.
// - After the dummy byte, table data leaves on falling clock edges.
// - Any start address; address increments after each byte sent.
// - After the top address the counter wraps to zero and continues.
// - Chip select high at any point ends the read and releases output.
// - Command refused while erase, program or write cycle is busy.
// - Bytes 0-3 signature 50444653h LSB first; 4 minor 00h, 5 major 01h.
// - Byte 6 header count 01h; byte 7 and unused header bytes FFh.
// - Header one: id 00h at 08h, minor 00h, major 01h at 0Ah.
// - Byte 0Bh gives standard table length 09h doublewords.
// - Bytes 0Ch-0Eh pointer 000030h LSB first; 0Fh returns FFh.
// - Header two: maker code at 10h, minor 00h, major 01h.
// - Byte 13h gives vendor table length 04h doublewords.
// - Bytes 14h-16h pointer 000060h LSB first; 17h returns FFh.
// - Byte 30h bits 1:0 are 01b, bit 2 is 1b.
// - Byte 30h bit 3 is 0b.
// - Byte 30h bit 4 is 0b.
// - Byte 30h bits 7:5 are always 111b.
`timescale 1ns/1ps
module ptr_responder #(
   parameter logic [7:0] MAKER_CODE = 8'ha5, // Arbitrary neutral value
   parameter int DEPTH = ptr_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Serial link pins
   input wire logic link_sclk,
   input wire logic link_csn,
   input wire logic link_si,
   output logic link_so,
   output logic link_so_oe,
   // Device state
   input wire logic busy_cycle,
   // Status
   output logic read_active,
   output logic cmd_refused
);
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_CMD = 4'b0010,
      ST_OUT = 4'b0100,
      ST_IGN = 4'b1000
   } ptr_state_t;

   // Three-stage pin synchronisers
   // First stage may be metastable; only the last two are compared
   logic [2:0] sclk_s, csn_s, si_s;
   logic sclk_q, csn_q;
   logic rise, fall, cs_low;
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sclk_s <= 3'h0;
         csn_s <= 3'h7;
         si_s <= 3'h0;
         sclk_q <= 1'b0;
         csn_q <= 1'b1;
      end
      else
      begin
         sclk_s <= {sclk_s[1:0], link_sclk};
         csn_s <= {csn_s[1:0], link_csn};
         si_s <= {si_s[1:0], link_si};
         if (sclk_s[1] == sclk_s[2])
            sclk_q <= sclk_s[2];
         if (csn_s[1] == csn_s[2])
            csn_q <= csn_s[2];
      end
   end
   assign rise = (sclk_s[1] == sclk_s[2]) && sclk_s[2] && !sclk_q;
   assign fall = (sclk_s[1] == sclk_s[2]) && !sclk_s[2] && sclk_q;
   assign cs_low = !csn_q && !(csn_s[1] && csn_s[2]);

   // Table lookup over the low address bits
   function automatic logic [7:0] table_byte(input logic [23:0] a);
      logic [7:0] b;
      b = ptr_pkg::BYTE_UNUSED;
      if (a[23:8] != 16'h0)
         b = ptr_pkg::BYTE_UNUSED;
      else if (a[7:2] == ptr_pkg::ADDR_SIG0[7:2])
         b = ptr_pkg::SIGNATURE[8*a[1:0] +: 8];
      else if (a[7:0] == ptr_pkg::ADDR_SIG0 + 8'h04)
         b = ptr_pkg::REV_MINOR;
      else if (a[7:0] == ptr_pkg::ADDR_SIG0 + 8'h05)
         b = ptr_pkg::REV_MAJOR;
      else if (a[7:0] == ptr_pkg::ADDR_SIG0 + 8'h06)
         b = ptr_pkg::HEADER_COUNT_FIELD;
      else if (a[7:0] == ptr_pkg::ADDR_HDR1)
         b = ptr_pkg::STD_TABLE_ID;
      else if (a[7:0] == ptr_pkg::ADDR_HDR1 + 8'h01)
         b = ptr_pkg::REV_MINOR;
      else if (a[7:0] == ptr_pkg::ADDR_HDR1 + 8'h02)
         b = ptr_pkg::REV_MAJOR;
      else if (a[7:0] == ptr_pkg::ADDR_HDR1 + 8'h03)
         b = ptr_pkg::STD_TABLE_LEN;
      else if (a[7:0] >= ptr_pkg::ADDR_HDR1 + 8'h04
               && a[7:0] <= ptr_pkg::ADDR_HDR1 + 8'h06)
         b = ptr_pkg::STD_TABLE_POINTER_FIELD[8*(a[1:0]) +: 8];
      else if (a[7:0] == ptr_pkg::ADDR_HDR2)
         b = MAKER_CODE;
      else if (a[7:0] == ptr_pkg::ADDR_HDR2 + 8'h01)
         b = ptr_pkg::REV_MINOR;
      else if (a[7:0] == ptr_pkg::ADDR_HDR2 + 8'h02)
         b = ptr_pkg::REV_MAJOR;
      else if (a[7:0] == ptr_pkg::ADDR_HDR2 + 8'h03)
         b = ptr_pkg::VND_TABLE_LEN;
      else if (a[7:0] >= ptr_pkg::ADDR_HDR2 + 8'h04
               && a[7:0] <= ptr_pkg::ADDR_HDR2 + 8'h06)
         b = ptr_pkg::VND_TABLE_POINTER_FIELD[8*(a[1:0]) +: 8];
      else if (a[7:0] == ptr_pkg::ADDR_PARAM0)
         b = {ptr_pkg::TOP_UNUSED, ptr_pkg::WREN_50, ptr_pkg::BP_NONVOL,
              ptr_pkg::GRAN_64, ptr_pkg::ERASE_4K};
      return b;
   endfunction : table_byte

   // Command state
   ptr_state_t st_q, st_d;
   logic [5:0] bitcnt_q, bitcnt_d;
   logic [31:0] sh_q, sh_d;
   logic [23:0] addr_q, addr_d;
   logic refused_q, refused_d;
   logic fetch;
   logic [7:0] fifo_out;
   logic fifo_valid, fifo_in_ready;
   logic pop;

   // Bytes are prefetched ahead of the shifter; fetch stalls when full
   assign fetch = (st_q == ST_OUT) && fifo_in_ready;

   always_comb
   begin
      st_d = st_q;
      bitcnt_d = bitcnt_q;
      sh_d = sh_q;
      addr_d = addr_q;
      refused_d = refused_q;
      if (!cs_low)
      begin
         st_d = ST_IDLE;
         bitcnt_d = 6'h0;
      end
      else
      begin
         case (st_q)
            ST_IDLE:
            begin
               st_d = ST_CMD;
               bitcnt_d = 6'h0;
               refused_d = 1'b0;
            end
            ST_CMD:
               if (rise)
               begin
                  sh_d = {sh_q[30:0], si_s[2]};
                  bitcnt_d = bitcnt_q + 6'h1;
                  if (bitcnt_q == 6'd7
                      && {sh_q[6:0], si_s[2]} != ptr_pkg::OPCODE_READ_PARAM)
                     st_d = ST_IGN;
                  else if (bitcnt_q == 6'd7 && busy_cycle)
                  begin
                     st_d = ST_IGN;
                     refused_d = 1'b1;
                  end
                  else if (bitcnt_q == 6'd31)
                     addr_d = {sh_q[22:0], si_s[2]};
                  else if (bitcnt_q == 6'd39)
                     st_d = ST_OUT;
               end
            ST_OUT:
               if (fetch)
                  addr_d = addr_q + 24'h1;
            default:
               st_d = st_q;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_q <= ST_IDLE;
         bitcnt_q <= 6'h0;
         sh_q <= 32'h0;
         addr_q <= 24'h0;
         refused_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         bitcnt_q <= bitcnt_d;
         sh_q <= sh_d;
         addr_q <= addr_d;
         refused_q <= refused_d;
      end
   end

   // Flushed outside the output phase, so a cut read leaves no stale bytes
   ptr_fifo #(
      .WIDTH(8),
      .DEPTH(DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .flush(st_q != ST_OUT),
      .in_valid(fetch),
      .in_ready(fifo_in_ready),
      .in_data(table_byte(addr_q)),
      .out_valid(fifo_valid),
      .out_ready(pop),
      .out_data(fifo_out)
   );

   // Output shifter, changes on falling serial clock
   logic [7:0] osh_q, osh_d;
   logic [2:0] obit_q, obit_d;
   logic so_q, so_d, oe_q, oe_d;

   // A byte leaves the FIFO only on the fall that starts it
   assign pop = (st_q == ST_OUT) && fall && (obit_q == 3'h0) && fifo_valid;

   always_comb
   begin
      osh_d = osh_q;
      obit_d = obit_q;
      so_d = so_q;
      oe_d = oe_q;
      if (st_q != ST_OUT || !cs_low)
      begin
         obit_d = 3'h0;
         oe_d = 1'b0;
         so_d = 1'b0;
      end
      else if (fall)
      begin
         if (obit_q == 3'h0)
         begin
            so_d = fifo_out[7];
            osh_d = {fifo_out[6:0], 1'b0};
            obit_d = 3'h7;
         end
         else
         begin
            so_d = osh_q[7];
            osh_d = {osh_q[6:0], 1'b0};
            obit_d = obit_q - 3'h1;
         end
         oe_d = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         osh_q <= 8'h0;
         obit_q <= 3'h0;
         so_q <= 1'b0;
         oe_q <= 1'b0;
      end
      else
      begin
         osh_q <= osh_d;
         obit_q <= obit_d;
         so_q <= so_d;
         oe_q <= oe_d;
      end
   end

   assign link_so = so_q;
   assign link_so_oe = oe_q;
   assign read_active = (st_q == ST_OUT);
   assign cmd_refused = refused_q;

   // Checks on the command and output paths
   a_refuse_busy: assert property (@(posedge sys_clk)
      disable iff (!resetn)
      st_q == ST_CMD && rise && cs_low && bitcnt_q == 6'd7 && busy_cycle
      && {sh_q[6:0], si_s[2]} == ptr_pkg::OPCODE_READ_PARAM
      |=> (st_q == ST_IGN && cmd_refused) ##0 (st_q != ST_OUT) [*8])
      else $error("command accepted during busy cycle");

   a_enter_out: assert property (@(posedge sys_clk)
      disable iff (!resetn)
      st_q == ST_CMD && rise && bitcnt_q == 6'd39 && cs_low
      |=> st_q == ST_OUT)
      else $error("output phase not entered after dummy byte");
   a_ign_quiet: assert property (@(posedge sys_clk)
      disable iff (!resetn) st_q == ST_IGN |-> !link_so_oe)
      else $error("output driven for an ignored command");

   a_cs_release: assert property (@(posedge sys_clk)
      disable iff (!resetn) !cs_low |=> !link_so_oe)
      else $error("output still driven after deselect");
   a_idle_quiet: assert property (@(posedge sys_clk)
      disable iff (!resetn) st_q == ST_IDLE |-> !link_so_oe && !link_so)
      else $error("output not released in idle");

   a_addr_step: assert property (@(posedge sys_clk)
      disable iff (!resetn)
      fetch && cs_low |=> addr_q == $past(addr_q) + 24'h1)
      else $error("address did not advance");
   a_addr_wrap: assert property (@(posedge sys_clk)
      disable iff (!resetn)
      fetch && cs_low && addr_q == 24'hffffff |=> addr_q == 24'h0)
      else $error("address did not wrap");

   a_oe_fall: assert property (@(posedge sys_clk)
      disable iff (!resetn) $rose(link_so_oe) |-> $past(fall))
      else $error("output started off a falling edge");
   a_so_hold: assert property (@(posedge sys_clk)
      disable iff (!resetn)
      $changed(link_so) |-> $past(fall) || !$past(cs_low)
         || $past(st_q) != ST_OUT)
      else $error("output bit changed off a falling edge");
   a_refused_quiet: assert property (@(posedge sys_clk)
      disable iff (!resetn) cmd_refused |-> !link_so_oe)
      else $error("output driven for a refused command");

   // Table contents are constant, so these hold in every cycle
   a_sig_byte: assert property (@(posedge sys_clk)
      disable iff (!resetn)
      table_byte(24'h0) == 8'h53 && table_byte(24'h3) == 8'h50)
      else $error("signature byte wrong");
   a_hdr_bytes: assert property (@(posedge sys_clk)
      disable iff (!resetn)
      table_byte(24'h06) == 8'h01 && table_byte(24'h0b) == 8'h09
      && table_byte(24'h0e) == 8'h00 && table_byte(24'h10) == MAKER_CODE)
      else $error("header byte wrong");
   a_param_byte: assert property (@(posedge sys_clk)
      disable iff (!resetn)
      table_byte(24'h30) == 8'he5 && table_byte(24'h07) == 8'hff)
      else $error("parameter byte wrong");

   // Main scenarios
   c_read: cover property (@(posedge sys_clk) st_q == ST_OUT && fall);
   c_refuse: cover property (@(posedge sys_clk) $rose(refused_q));
   c_wrap: cover property (@(posedge sys_clk) fetch && addr_q == 24'hffffff);
   c_cut: cover property (@(posedge sys_clk) st_q == ST_OUT && !cs_low
      && obit_q != 3'h0);
   c_full: cover property (@(posedge sys_clk) st_q == ST_OUT
      && !fifo_in_ready);
endmodule : ptr_responder

// [sim/param_table_read_responder_tb.sv]
// Self-checking bench for the parameter table read responder
`timescale 1ns/1ps
module param_table_read_responder_tb;
   localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value
   logic sys_clk, resetn, busy_cycle;
   logic link_sclk, link_csn, link_si, link_so, link_so_oe;
   logic read_active, cmd_refused;
   int active_cycles = 0;
   int act0;
   int miscompares = 0;
   int check_count = 0;
   logic [7:0] hdr_tab [24] = '{
      8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01,
      8'h01, 8'hff,
      8'h00, 8'h00, 8'h01,
      8'h09,
      8'h30, 8'h00, 8'h00, 8'hff,
      MAKER, 8'h00, 8'h01,
      8'h04,
      8'h60, 8'h00, 8'h00, 8'hff};

   ptr_responder #(.MAKER_CODE(MAKER)) ptr_responder_i (
      .sys_clk(sys_clk), .resetn(resetn), .link_sclk(link_sclk),
      .link_csn(link_csn), .link_si(link_si), .link_so(link_so),
      .link_so_oe(link_so_oe), .busy_cycle(busy_cycle),
      .read_active(read_active), .cmd_refused(cmd_refused));
   ptr_host_model ptr_host_model_i (
      .link_sclk(link_sclk), .link_csn(link_csn), .link_si(link_si),
      .link_so(link_so), .link_so_oe(link_so_oe));

   // Cycles spent in the output phase, for the read_active checks
   always @(posedge sys_clk)
      if (read_active === 1'b1)
         active_cycles <= active_cycles + 1;

   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   function automatic logic [7:0] exp_byte(input logic [23:0] a);
      if (a < 24'h18)
         return hdr_tab[a[4:0]];
      return (a == 24'h30) ? 8'he5 : 8'hff;
   endfunction : exp_byte

   task automatic chk(input string what, input logic [7:0] e,
                      input logic [7:0] g);
      check_count++;
      if (g !== e)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask : chk

   task automatic results();
      $display("Checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results

   // Output released and idle once select has been high a while
   task automatic gap();
      repeat (8) @(posedge sys_clk);
      #5;
      chk("so_oe idle", 8'h00, {7'h0, link_so_oe});
      chk("read_active idle", 8'h00, {7'h0, read_active});
      chk("so idle", 8'h00, {7'h0, link_so});
   endtask : gap

   task automatic rd(input logic [23:0] a, input int n);
      int n0;
      n0 = active_cycles;
      ptr_host_model_i.xfer(8'h5a, a, n);
      chk("oe seen", 8'h01, {7'h0, ptr_host_model_i.oe_seen});
      chk("read_active", 8'h01, {7'h0, active_cycles > n0});
      for (int k = 0; k < n; k++)
         chk("byte", exp_byte(a + 24'(k)), ptr_host_model_i.rx_q[k]);
      gap();
   endtask : rd

   initial
   begin
      resetn = 1'b0;
      busy_cycle = 1'b0;
      act0 = 0;
      repeat (8) @(posedge sys_clk);
      chk("so_oe reset", 8'h00, {7'h0, link_so_oe});
      chk("refused reset", 8'h00, {7'h0, cmd_refused});
      #5 resetn = 1'b1;
      repeat (4) @(posedge sys_clk);
      rd(24'h000000, 24);
      rd(24'h00000d, 5);
      rd(24'h000030, 2);
      rd(24'hfffffe, 4);
      @(posedge sys_clk);
      #5 busy_cycle = 1'b1;
      act0 = active_cycles;
      ptr_host_model_i.xfer(8'h5a, 24'h000000, 1);
      chk("refused", 8'h01, {7'h0, cmd_refused});
      chk("oe busy", 8'h00, {7'h0, ptr_host_model_i.oe_seen});
      chk("active busy", 8'h00, {7'h0, active_cycles != act0});
      @(posedge sys_clk);
      #5 busy_cycle = 1'b0;
      gap();
      rd(24'h000004, 2);
      chk("refused cleared", 8'h00, {7'h0, cmd_refused});
      act0 = active_cycles;
      ptr_host_model_i.xfer(8'h03, 24'h000000, 1);
      chk("oe bad opcode", 8'h00, {7'h0, ptr_host_model_i.oe_seen});
      chk("active bad op", 8'h00, {7'h0, active_cycles != act0});
      gap();
      act0 = active_cycles;
      ptr_host_model_i.cut(24'h000010);
      chk("oe cut", 8'h01, {7'h0, ptr_host_model_i.oe_seen});
      chk("active cut", 8'h01, {7'h0, active_cycles != act0});
      gap();
      rd(24'h000028, 20);
      results();
   end

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      results();
   end
endmodule : param_table_read_responder_tb

// [sim/ptr_host_model.sv]
// Host serial controller model that drives the link pins
`timescale 1ns/1ps
module ptr_host_model (
   // Link pins
   output logic link_sclk,
   output logic link_csn,
   output logic link_si,
   input wire logic link_so,
   input wire logic link_so_oe
);
   logic [7:0] rx_q[$];
   logic oe_seen;

   initial
   begin
      link_sclk = 1'b0;
      link_csn = 1'b1;
      link_si = 1'b1;
      oe_seen = 1'b0;
   end

   // Samples late in the bit, since the output lags the falling edge
   task automatic xfer(input logic [7:0] op, input logic [23:0] addr,
                       input int nbytes);
      logic [39:0] hdr;
      logic [7:0] b;
      hdr = {op, addr, 8'h00};
      rx_q.delete();
      oe_seen = 1'b0;
      link_csn = 1'b0;
      for (int i = 39; i >= 0; i--)
      begin
         link_si = hdr[i];
         #400 link_sclk = 1'b1;
         #400 link_sclk = 1'b0;
      end
      for (int n = 0; n < nbytes; n++)
      begin
         for (int j = 7; j >= 0; j--)
         begin
            link_si = ~link_si;
            #400 link_sclk = 1'b1;
            #399 b[j] = link_so;
            oe_seen = oe_seen | (link_so_oe === 1'b1);
            #1 link_sclk = 1'b0;
         end
         rx_q.push_back(b);
      end
      // Clock stands still low outside frames
      #400 link_csn = 1'b1;
   endtask : xfer

   // Select raised in the middle of a data byte
   task automatic cut(input logic [23:0] addr);
      logic [39:0] hdr;
      hdr = {8'h5a, addr, 8'h00};
      oe_seen = 1'b0;
      link_csn = 1'b0;
      for (int i = 39; i >= -3; i--)
      begin
         link_si = (i >= 0) ? hdr[i] : 1'b0;
         #400 link_sclk = 1'b1;
         #400 link_sclk = 1'b0;
      end
      #399 oe_seen = (link_so_oe === 1'b1);
      #1 link_csn = 1'b1;
   endtask : cut
endmodule : ptr_host_model
